//--- sms_checker.sv
// Purpose: protocol checks on the host to sequencer link
// Assumes: one clock, asynchronous active-low reset
// Notes: sees link signals only, instantiated beside the link
`timescale 1ns/1ps
module sms_checker (
  input wire logic                      i_clk,
  input wire logic                      i_rst_n,
  input wire logic                      cmd_valid,
  input wire logic [2:0]                cmd_op,
  input wire logic                      status_valid,
  input wire logic                      sys_init,
  input wire logic [sms_pkg::ERR_W-1:0] err,
  input wire logic [7:0]                tag,
  input wire sms_pkg::stage_t           stage,
  input wire sms_pkg::opmode_t          opmode,
  input wire logic                      cmd_refused
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // taken command, flash-program and self-test commands, main stage
  wire take    = cmd_valid && sys_init;
  wire sb_cmd  = cmd_op inside {sms_pkg::CMD_FLASH_PROG, sms_pkg::CMD_SELFTEST};
  wire in_main = stage == sms_pkg::STAGE_MAIN;

  a_cmd_after_init: assert property (cmd_valid |-> sys_init)
    else $error("command sent before init");
  a_refuse_display: assert property (
    take && opmode == sms_pkg::OPM_DISPLAY && sb_cmd |=> cmd_refused && err[sms_pkg::ERR_CMD])
    else $error("display accepted a standby-only command");
  a_accept_standby: assert property (
    take && in_main && opmode == sms_pkg::OPM_STANDBY && sb_cmd |=> !cmd_refused)
    else $error("standby refused a standby command");
  a_refused_flag: assert property (cmd_refused |-> err[sms_pkg::ERR_CMD])
    else $error("refusal without command error");
  a_clear_errors: assert property (
    take && cmd_op == sms_pkg::CMD_CLR_STATUS |=> err == '0)
    else $error("clear left error bits");
  a_standby_first: assert property (
    opmode != sms_pkg::OPM_NONE && $past(opmode) == sms_pkg::OPM_NONE
    |-> opmode == sms_pkg::OPM_STANDBY)
    else $error("first mode was not standby");
  a_init_status: assert property (sys_init |-> status_valid)
    else $error("init flag with invalid status");
  a_init_held: assert property (sys_init |=> sys_init)
    else $error("init flag dropped");
  a_tag_legal: assert property (sys_init |-> tag == sms_pkg::TAG_DEFAULT ||
    tag == sms_pkg::TAG_NULL || (tag >= sms_pkg::TAG_HOST_LO && tag <= sms_pkg::TAG_HOST_HI))
    else $error("status tag out of range");
  a_mode_select: assert property (
    take && in_main && cmd_op == sms_pkg::CMD_MODE_DISP |=> opmode == sms_pkg::OPM_DISPLAY)
    else $error("display command ignored");
endmodule : sms_checker

//--- sms_device.sv
// Purpose: startup and operating-mode sequencer, device end
// Assumes: straps and flash results arrive as synchronous inputs
// Notes: flash loading and self-tests are external engines started by pulses
`timescale 1ns/1ps
module sms_device (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  sms_link_if.device       link,
  input  wire logic        i_strap_if_sel,   // host interface select strap
  input  wire logic        i_strap_hold,     // hold-in-loader strap
  input  wire logic        i_hw_init_done,
  input  wire logic        i_load_done,
  input  wire logic        i_verify_ok,
  input  wire logic        i_clk_init_done,
  input  wire logic [1:0]  i_reset_cause,
  input  wire logic        i_opt_bist_en,    // flash option: entry self-tests
  input  wire logic        i_opt_auto_disp,  // flash option: go to display
  input  wire logic        i_bist_done,
  input  wire logic        i_bist_fail,
  input  wire logic        i_batch_done,
  input  wire logic        i_batch_fail,
  input  wire logic        i_batch_mode_req, // batch asks for a mode
  input  wire logic        i_batch_mode_disp,
  input  wire logic        i_sys_fault,      // internal condition, forces standby in ST_RUN, a same-cycle host display command wins
  input  wire logic        i_tag_corrupt,
  output logic             o_if_is_spi,
  output logic [1:0]       o_reset_cause,
  output logic             o_load_start,
  output logic             o_bist_start,
  output logic             o_periodic_start,
  output logic             o_batch_start,
  output logic             o_flash_prog,
  output logic             o_video_en,
  output logic             o_illum_en,
  output logic             o_mirror_park
);

  typedef enum logic [3:0] {
    ST_HWINIT, ST_STRAP_IF, ST_STRAP_HOLD, ST_LOAD, ST_BOOT_WAIT,
    ST_CLKINIT, ST_ENTRY_BIST, ST_BATCH, ST_RUN
  } seq_t;

  seq_t                          st_q, st_d;
  sms_pkg::stage_t               stage_q, stage_d;
  sms_pkg::opmode_t              mode_q, mode_d;
  logic                          init_q, init_d;
  logic [sms_pkg::ERR_W-1:0]     err_q, err_d, hist_q, hist_d;
  logic [7:0]                    tag_q, tag_d;
  logic [7:0]                    per_q, per_d;
  logic                          if_q, if_d, hold_q, hold_d;
  logic [1:0]                    cause_q, cause_d;
  logic                          refuse_q, refuse_d;
  logic                          pulse_load_d, pulse_bist_d, pulse_batch_d, pulse_per_d;
  logic                          pulse_load_q, pulse_bist_q, pulse_batch_q, pulse_per_q;
  logic                          fprog_q, fprog_d;
  logic [sms_pkg::ERR_W-1:0]     err_set;  // hardware error events this cycle

  // command decode
  wire in_standby = (mode_q == sms_pkg::OPM_STANDBY) && (st_q == ST_RUN);
  wire in_boot    = (st_q == ST_BOOT_WAIT);
  wire entry_done = i_bist_done || !i_opt_bist_en;  // no entry tests: done at once
  wire cmd_ok     = link.cmd_valid && init_q;
  wire is_maint   = (link.cmd_op == sms_pkg::CMD_FLASH_PROG) ||
                    (link.cmd_op == sms_pkg::CMD_SELFTEST);
  wire maint_ok   = in_standby ||
                    (in_boot && link.cmd_op == sms_pkg::CMD_FLASH_PROG);
  wire tag_host   = (link.cmd_tag >= sms_pkg::TAG_HOST_LO) &&
                    (link.cmd_tag <= sms_pkg::TAG_HOST_HI);

  // sequencing and status next state
  always_comb begin
    st_d = st_q; stage_d = stage_q; mode_d = mode_q; init_d = init_q;
    err_d = err_q; hist_d = hist_q; tag_d = tag_q; per_d = per_q;
    if_d = if_q; hold_d = hold_q; cause_d = cause_q; refuse_d = 1'b0;
    pulse_load_d = 1'b0; pulse_bist_d = 1'b0; pulse_batch_d = 1'b0;
    pulse_per_d = 1'b0; fprog_d = 1'b0;
    err_set = '0;
    case (st_q)
      ST_HWINIT: if (i_hw_init_done) st_d = ST_STRAP_IF;
      ST_STRAP_IF: begin
        if_d = i_strap_if_sel;
        st_d = ST_STRAP_HOLD;
      end
      ST_STRAP_HOLD: begin
        hold_d = i_strap_hold;
        if (i_strap_hold) begin
          st_d = ST_BOOT_WAIT;
        end else begin
          pulse_load_d = 1'b1;
          st_d = ST_LOAD;
        end
      end
      ST_LOAD: if (i_load_done) begin
        if (i_verify_ok) begin
          stage_d = sms_pkg::STAGE_MAIN;
          st_d = ST_CLKINIT;
        end else begin
          err_set[sms_pkg::ERR_OPER] = 1'b1;
          st_d = ST_BOOT_WAIT;
        end
      end
      ST_BOOT_WAIT: init_d = 1'b1;
      ST_CLKINIT: if (i_clk_init_done) begin
        cause_d = i_reset_cause;
        mode_d = sms_pkg::OPM_STANDBY;
        pulse_bist_d = i_opt_bist_en;
        st_d = ST_ENTRY_BIST;
      end
      // standby always seen for a cycle, even when display follows at once
      ST_ENTRY_BIST: if (entry_done) begin
        if (i_opt_bist_en && i_bist_fail) err_set[sms_pkg::ERR_BIST] = 1'b1;
        if (i_opt_auto_disp) mode_d = sms_pkg::OPM_DISPLAY;
        pulse_batch_d = 1'b1;
        st_d = ST_BATCH;
      end
      ST_BATCH: begin
        if (i_batch_mode_req) begin
          mode_d = i_batch_mode_disp ? sms_pkg::OPM_DISPLAY : sms_pkg::OPM_STANDBY;
        end
        if (i_batch_done) begin
          if (i_batch_fail) err_set[sms_pkg::ERR_OPER] = 1'b1;
          init_d = 1'b1;
          tag_d = sms_pkg::TAG_DEFAULT;
          st_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (mode_q == sms_pkg::OPM_DISPLAY) begin
          per_d = (per_q == sms_pkg::PERIODIC_LAST) ? 8'h00 : per_q + 8'h01;
          pulse_per_d = (per_q == sms_pkg::PERIODIC_LAST);
          if (i_bist_fail) err_set[sms_pkg::ERR_BIST] = 1'b1;
        end else begin
          per_d = 8'h00;
        end
        if (i_sys_fault) mode_d = sms_pkg::OPM_STANDBY;
      end
      default: st_d = ST_HWINIT;
    endcase
    // host commands, accepted only once initialised
    if (cmd_ok) begin
      tag_d = tag_host ? link.cmd_tag : sms_pkg::TAG_NULL;
      case (link.cmd_op)
        sms_pkg::CMD_MODE_STBY: if (st_q == ST_RUN) mode_d = sms_pkg::OPM_STANDBY;
        sms_pkg::CMD_MODE_DISP: if (st_q == ST_RUN) mode_d = sms_pkg::OPM_DISPLAY;
        sms_pkg::CMD_CLR_STATUS: begin
          err_d = '0;
          hist_d = '0;
          tag_d = sms_pkg::TAG_DEFAULT;
        end
        default: ;
      endcase
      if (is_maint) begin
        if (maint_ok) begin
          fprog_d = (link.cmd_op == sms_pkg::CMD_FLASH_PROG);
          pulse_bist_d = (link.cmd_op == sms_pkg::CMD_SELFTEST);
        end else begin
          refuse_d = 1'b1;
          err_d[sms_pkg::ERR_CMD] = 1'b1;
          hist_d[sms_pkg::ERR_CMD] = 1'b1;
        end
      end
    end
    // hardware error events win over a same-cycle clear
    err_d = err_d | err_set;
    hist_d = hist_d | err_set;
    if (i_tag_corrupt) tag_d = sms_pkg::TAG_NULL;
  end

  // state registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= ST_HWINIT; stage_q <= sms_pkg::STAGE_LOADER; mode_q <= sms_pkg::OPM_NONE;
      init_q <= 1'b0; err_q <= '0; hist_q <= '0; tag_q <= sms_pkg::TAG_DEFAULT;
      per_q <= 8'h00; if_q <= 1'b0; hold_q <= 1'b0; cause_q <= 2'h0;
      refuse_q <= 1'b0; pulse_load_q <= 1'b0; pulse_bist_q <= 1'b0;
      pulse_batch_q <= 1'b0; pulse_per_q <= 1'b0; fprog_q <= 1'b0;
    end else begin
      st_q <= st_d; stage_q <= stage_d; mode_q <= mode_d;
      init_q <= init_d; err_q <= err_d; hist_q <= hist_d; tag_q <= tag_d;
      per_q <= per_d; if_q <= if_d; hold_q <= hold_d; cause_q <= cause_d;
      refuse_q <= refuse_d; pulse_load_q <= pulse_load_d; pulse_bist_q <= pulse_bist_d;
      pulse_batch_q <= pulse_batch_d; pulse_per_q <= pulse_per_d; fprog_q <= fprog_d;
    end
  end

  // link status and engine controls
  assign link.status_valid = init_q;
  assign link.sys_init     = init_q;
  assign link.err          = init_q ? err_q : '1;
  assign link.tag          = tag_q;
  assign link.stage        = stage_q;
  assign link.opmode       = mode_q;
  assign link.cmd_refused  = refuse_q;
  assign link.err_hist     = hist_q;
  assign o_if_is_spi       = if_q;
  assign o_reset_cause     = cause_q;
  assign o_load_start      = pulse_load_q;
  assign o_bist_start      = pulse_bist_q;
  assign o_periodic_start  = pulse_per_q;
  assign o_batch_start     = pulse_batch_q;
  assign o_flash_prog      = fprog_q;
  wire   disp_run          = (mode_q == sms_pkg::OPM_DISPLAY) && (st_q == ST_RUN);
  assign o_video_en        = disp_run;
  assign o_illum_en        = disp_run;
  assign o_mirror_park     = !disp_run;

endmodule : sms_device

//--- sms_host.sv
// Purpose: host end, startup readiness check and command issue
// Assumes: device status fields are levels on the link
// Notes: user command port is accepted only after startup checks pass
`timescale 1ns/1ps
module sms_host (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  sms_link_if.host              link,
  input  wire sms_pkg::stage_t  i_exp_stage,
  input  wire sms_pkg::opmode_t i_exp_mode,
  input  wire logic             i_req_valid,
  input  wire logic [2:0]       i_req_op,
  output logic                  o_req_ready,
  output logic                  o_ready,     // startup checks passed
  output logic                  o_mismatch,  // stage or mode not as expected
  output logic [3:0]            o_err_seen
);

  typedef enum logic [2:0] {H_POLL, H_READ_HIST, H_CLEAR, H_CHECK, H_READY, H_BAD} hst_t;

  hst_t        st_q, st_d;
  logic [7:0]  tag_q, tag_d;
  logic [3:0]  seen_q, seen_d;
  logic        cv_q, cv_d;
  logic [2:0]  op_q, op_d;

  wire err_any = |link.err;
  wire match   = (link.stage == i_exp_stage) && (link.opmode == i_exp_mode);
  wire [7:0] tag_nxt = (tag_q == sms_pkg::TAG_HOST_HI) ? sms_pkg::TAG_HOST_LO : tag_q + 8'h01;

  // startup flow
  always_comb begin
    st_d = st_q; tag_d = tag_q; seen_d = seen_q; cv_d = 1'b0; op_d = op_q;
    case (st_q)
      H_POLL: if (link.status_valid && link.sys_init) begin
        st_d = err_any ? H_READ_HIST : H_CHECK;
      end
      H_READ_HIST: begin
        seen_d = link.err_hist;
        st_d = H_CLEAR;
      end
      H_CLEAR: begin
        cv_d = 1'b1; op_d = sms_pkg::CMD_CLR_STATUS; tag_d = tag_nxt;
        st_d = H_CHECK;
      end
      H_CHECK: if (!cv_q) st_d = match ? H_READY : H_BAD;
      H_READY: if (i_req_valid) begin
        cv_d = 1'b1; op_d = i_req_op; tag_d = tag_nxt;
      end
      H_BAD: ;
      default: st_d = H_POLL;
    endcase
  end

  // host registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= H_POLL; tag_q <= sms_pkg::TAG_DEFAULT; seen_q <= 4'h0;
      cv_q <= 1'b0; op_q <= sms_pkg::CMD_NONE;
    end else begin
      st_q <= st_d; tag_q <= tag_d; seen_q <= seen_d; cv_q <= cv_d; op_q <= op_d;
    end
  end

  assign link.cmd_valid = cv_q;
  assign link.cmd_op    = op_q;
  assign link.cmd_tag   = tag_q;
  assign o_req_ready    = (st_q == H_READY);
  assign o_ready        = (st_q == H_READY);
  assign o_mismatch     = (st_q == H_BAD);
  assign o_err_seen     = seen_q;

endmodule : sms_host

//--- sms_link_if.sv
// Purpose: link between host and the startup mode sequencer
// Assumes: synchronous single clock, one-cycle command strobe
// Notes: answers are levels driven by the device, except cmd_refused, a one-cycle pulse
`timescale 1ns/1ps
interface sms_link_if;
  logic                   cmd_valid;  // host command strobe
  logic [2:0]             cmd_op;
  logic [7:0]             cmd_tag;
  logic                   status_valid; // status readable, else nak/invalid
  logic                   sys_init;
  logic [sms_pkg::ERR_W-1:0] err;
  logic [7:0]             tag;
  sms_pkg::stage_t        stage;
  sms_pkg::opmode_t       opmode;
  logic                   cmd_refused;  // pulse, last command refused
  logic [sms_pkg::ERR_W-1:0] err_hist;

  modport device (input cmd_valid, cmd_op, cmd_tag,
                  output status_valid, sys_init, err, tag, stage, opmode,
                  cmd_refused, err_hist);
  modport host   (output cmd_valid, cmd_op, cmd_tag,
                  input status_valid, sys_init, err, tag, stage, opmode,
                  cmd_refused, err_hist);
endinterface : sms_link_if

//--- sms_pkg.sv
// Purpose: shared constants and types for the startup mode sequencer and its host
// Assumes: one clock domain, status carried as plain fields on the link
// Notes: tag values and status field layout live here only
package sms_pkg;

  localparam logic [7:0] TAG_DEFAULT = 8'h00;
  localparam logic [7:0] TAG_NULL    = 8'hff;
  localparam logic [7:0] TAG_HOST_LO = 8'h01;
  localparam logic [7:0] TAG_HOST_HI = 8'hcf;

  // host command opcodes on the link
  localparam logic [2:0] CMD_NONE       = 3'h0;
  localparam logic [2:0] CMD_MODE_STBY  = 3'h1;
  localparam logic [2:0] CMD_MODE_DISP  = 3'h2;
  localparam logic [2:0] CMD_FLASH_PROG = 3'h3;
  localparam logic [2:0] CMD_SELFTEST   = 3'h4;
  localparam logic [2:0] CMD_CLR_STATUS = 3'h5;
  localparam logic [2:0] CMD_READ_HIST  = 3'h6;

  // error bit positions in the status error field
  localparam int ERR_COMM  = 0;
  localparam int ERR_CMD   = 1;
  localparam int ERR_BIST  = 2;
  localparam int ERR_OPER  = 3;
  localparam int ERR_W     = 4;

  // periodic self-test interval in cycles
  localparam int PERIODIC_CYC = 64;
  localparam logic [7:0] PERIODIC_LAST = 8'(PERIODIC_CYC - 1);

  typedef enum logic {STAGE_LOADER, STAGE_MAIN} stage_t;
  typedef enum logic [1:0] {OPM_NONE, OPM_STANDBY, OPM_DISPLAY} opmode_t;

endpackage : sms_pkg

//--- tb.sv
// Purpose: self-checking bench joining sequencer and host over the link
// Assumes: done inputs held as levels, 200 MHz clock
// Notes: driver queues expected states, a monitor compares them
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    sms_pkg::stage_t  stage;
    sms_pkg::opmode_t mode;
    logic [3:0]       err;
    logic             vid;
  } exp_t;
  logic             i_clk = 1'b0;
  logic             i_rst_n = 1'b0;
  logic             strap_if, hold, vok, bist_en, auto_disp, fault, corrupt, dn, req_v, chk;
  logic [1:0]       cause, cause_q;
  logic [2:0]       req_op;
  sms_pkg::stage_t  exp_stage;
  sms_pkg::opmode_t exp_mode;
  logic             if_spi, load_st, bist_st, per_st, fprog, vid, ill, park, req_rdy, rdy, mism;
  logic [3:0]       err_seen;
  logic             batch_st;
  exp_t             q[$];
  exp_t             e;
  int               err_count = 0;
  int               check_count = 0;
  int               n_bist = 0, n_per = 0, n_load = 0, n_prog = 0, b0;
  int               n_batch = 0, b1;

  sms_link_if link ();
  always #2.5 i_clk = ~i_clk;

  sms_device sms_device_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(link.device),
    .i_strap_if_sel(strap_if), .i_strap_hold(hold), .i_hw_init_done(dn), .i_load_done(dn),
    .i_verify_ok(vok), .i_clk_init_done(dn), .i_reset_cause(cause), .i_opt_bist_en(bist_en),
    .i_opt_auto_disp(auto_disp), .i_bist_done(dn), .i_bist_fail(1'b0), .i_batch_done(dn),
    .i_batch_fail(1'b0), .i_batch_mode_req(1'b0), .i_batch_mode_disp(1'b0),
    .i_sys_fault(fault), .i_tag_corrupt(corrupt), .o_if_is_spi(if_spi),
    .o_reset_cause(cause_q), .o_load_start(load_st), .o_bist_start(bist_st),
    .o_periodic_start(per_st), .o_batch_start(batch_st), .o_flash_prog(fprog),
    .o_video_en(vid), .o_illum_en(ill), .o_mirror_park(park));
  sms_host sms_host_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(link.host),
    .i_exp_stage(exp_stage), .i_exp_mode(exp_mode), .i_req_valid(req_v), .i_req_op(req_op),
    .o_req_ready(req_rdy), .o_ready(rdy), .o_mismatch(mism), .o_err_seen(err_seen));
  sms_checker sms_checker_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .cmd_valid(link.cmd_valid),
    .cmd_op(link.cmd_op), .status_valid(link.status_valid), .sys_init(link.sys_init),
    .err(link.err), .tag(link.tag), .stage(link.stage), .opmode(link.opmode),
    .cmd_refused(link.cmd_refused));

  // pulse counters
  always @(posedge i_clk) begin
    n_bist <= n_bist + int'(bist_st === 1'b1);
    n_per  <= n_per + int'(per_st === 1'b1);
    n_load <= n_load + int'(load_st === 1'b1);
    n_prog <= n_prog + int'(fprog === 1'b1);
    n_batch <= n_batch + int'(batch_st === 1'b1);
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_state(input exp_t x);
    check_count++;
    if ({link.stage, link.opmode, link.err, vid, ill, park} !==
        {x.stage, x.mode, x.err, x.vid, x.vid, ~x.vid}) begin
      err_count++;
      $display("CHECK FAILED t=%0t state mismatch exp %h", $time, x);
    end
  endtask : cmp_state

  // monitor: oldest note against the live status
  always @(posedge i_clk) begin
    if (chk) begin
      e = q.pop_front();
      cmp_state(e);
    end
  end

  task automatic note(input sms_pkg::stage_t s, input sms_pkg::opmode_t m, input logic [3:0] r);
    q.push_back('{s, m, r, m == sms_pkg::OPM_DISPLAY});
    chk <= 1'b1;
    @(posedge i_clk);
    chk <= 1'b0;
    @(posedge i_clk);
  endtask : note

  // reset with new straps and options, then wait for the host verdict
  task automatic boot(input logic h, input logic v, input logic a, input sms_pkg::opmode_t m);
    hold <= h;
    vok <= v;
    auto_disp <= a;
    cause <= 2'($urandom);
    strap_if <= 1'($urandom);
    exp_mode <= m;
    exp_stage <= (h | ~v) ? sms_pkg::STAGE_LOADER : sms_pkg::STAGE_MAIN;
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    for (int i = 0; i < 400 && rdy !== 1'b1 && mism !== 1'b1; i++) @(posedge i_clk);
  endtask : boot

  // user command through the host, then the device answer
  task automatic send(input logic [2:0] op);
    for (int i = 0; i < 50 && req_rdy !== 1'b1; i++) @(posedge i_clk);
    req_v <= 1'b1;
    req_op <= op;
    @(posedge i_clk);
    req_v <= 1'b0;
    for (int i = 0; i < 20 && link.cmd_valid !== 1'b1; i++) @(posedge i_clk);
    repeat (2) @(posedge i_clk);
  endtask : send

  // watchdog
  initial begin
    repeat (20000) @(posedge i_clk);
    err_count++;
    give_verdict();
  end

  initial begin
    {strap_if, hold, vok, bist_en, auto_disp, fault, corrupt, req_v, chk} = '0;
    dn = 1'b1;
    cause = 2'h0;
    req_op = 3'h0;
    exp_stage = sms_pkg::STAGE_MAIN;
    exp_mode = sms_pkg::OPM_STANDBY;
    void'($urandom(32'hd65e));
    // entry self-tests on, stay in standby
    bist_en = 1'b1;
    b0 = n_bist;
    boot(1'b0, 1'b1, 1'b0, sms_pkg::OPM_STANDBY);
    note(sms_pkg::STAGE_MAIN, sms_pkg::OPM_STANDBY, 4'h0);
    cmp_val(8'(rdy), 8'h1, "ready");
    cmp_val(8'(req_rdy), 8'h1, "req ready");
    cmp_val(8'(n_bist - b0), 8'h1, "entry bist");
    cmp_val(8'(cause_q), 8'(cause), "cause");
    cmp_val(8'(if_spi), 8'(strap_if), "if strap");
    cmp_val(link.tag, sms_pkg::TAG_DEFAULT, "tag");
    b0 = n_bist;
    send(sms_pkg::CMD_SELFTEST);
    cmp_val(8'(n_bist - b0), 8'h1, "bist cmd");
    b0 = n_prog;
    send(sms_pkg::CMD_FLASH_PROG);
    cmp_val(8'(n_prog - b0), 8'h1, "flash cmd");
    send(sms_pkg::CMD_MODE_DISP);
    note(sms_pkg::STAGE_MAIN, sms_pkg::OPM_DISPLAY, 4'h0);
    b0 = n_per;
    repeat (130) @(posedge i_clk);
    cmp_val(8'(n_per - b0 >= 2), 8'h1, "periodic");
    send(sms_pkg::CMD_FLASH_PROG);
    note(sms_pkg::STAGE_MAIN, sms_pkg::OPM_DISPLAY, 4'h2);
    send(sms_pkg::CMD_CLR_STATUS);
    note(sms_pkg::STAGE_MAIN, sms_pkg::OPM_DISPLAY, 4'h0);
    corrupt <= 1'b1;
    repeat (3) @(posedge i_clk);
    cmp_val(link.tag, sms_pkg::TAG_NULL, "null tag");
    corrupt <= 1'b0;
    fault <= 1'b1;
    @(posedge i_clk);
    fault <= 1'b0;
    repeat (3) @(posedge i_clk);
    cmp_val(8'(link.opmode), 8'(sms_pkg::OPM_STANDBY), "fault mode");
    // auto display, host expects standby
    bist_en <= 1'b0;
    b0 = n_bist;
    b1 = n_batch;
    boot(1'b0, 1'b1, 1'b1, sms_pkg::OPM_STANDBY);
    cmp_val(8'(n_batch - b1), 8'h1, "batch");
    note(sms_pkg::STAGE_MAIN, sms_pkg::OPM_DISPLAY, 4'h0);
    cmp_val(8'({mism, rdy}), 8'h2, "mismatch");
    cmp_val(8'(n_bist - b0), 8'h0, "no bist");
    // hold in loader
    b0 = n_load;
    boot(1'b1, 1'b1, 1'b0, sms_pkg::OPM_NONE);
    note(sms_pkg::STAGE_LOADER, sms_pkg::OPM_NONE, 4'h0);
    cmp_val(8'(n_load - b0), 8'h0, "no load");
    cmp_val(8'(link.sys_init), 8'h1, "loader init");
    // verify failure, host reads and clears
    boot(1'b0, 1'b0, 1'b0, sms_pkg::OPM_NONE);
    note(sms_pkg::STAGE_LOADER, sms_pkg::OPM_NONE, 4'h0);
    cmp_val(8'(err_seen[sms_pkg::ERR_OPER]), 8'h1, "load fail");
    give_verdict();
  end
endmodule : tb
